// ### logic/dph_pkg.sv
// package: constants for the peripheral request handshake
`default_nettype none
package dph_pkg;
  localparam int unsigned NUM_IF       = 32;
  localparam int unsigned NUM_FABRIC   = 8;
  localparam logic [4:0]  ID_SHARED_LO = 5'h06;
  localparam logic [4:0]  ID_SHARED_HI = 5'h07;
  localparam logic [4:0]  ID_TRACE     = 5'h1A;
  localparam logic [31:0] RESERVED_IDS = 32'h0B000000;
  localparam logic [31:0] EN_RESET     = 32'h00000000;
  localparam logic [1:0]  RQ_SINGLE = 2'h0;
  localparam logic [1:0]  RQ_BURST  = 2'h1;
  localparam logic [1:0]  RQ_FLUSH_ACK = 2'h2;
  localparam logic [1:0]  RQ_RSVD   = 2'h3;
  localparam logic [1:0]  AK_SINGLE = 2'h0;
  localparam logic [1:0]  AK_BURST  = 2'h1;
  localparam logic [1:0]  AK_FLUSH  = 2'h2;
  localparam logic [1:0]  AK_RSVD   = 2'h3;
endpackage : dph_pkg
`default_nettype wire

// ### logic/dph_if.sv
// interface: one request/acknowledge channel between controller and requester
`timescale 1ns/1ps
`default_nettype none
interface dph_if;
  logic       fabric_burst_request;
  logic       fabric_single_request;
  logic       fabric_transfer_acknowledge;
  logic       req_valid;
  logic       req_ready;
  logic [1:0] req_type;
  logic       req_last;
  logic       ack_valid;
  logic       ack_ready;
  logic [1:0] ack_type;
  modport ctrl (input fabric_burst_request, fabric_single_request, req_valid, req_type, req_last, ack_ready,
                output fabric_transfer_acknowledge, req_ready, ack_valid, ack_type);
  modport periph (output fabric_burst_request, fabric_single_request, req_valid, req_type, req_last, ack_ready,
                  input fabric_transfer_acknowledge, req_ready, ack_valid, ack_type);
endinterface : dph_if
`default_nettype wire

// ### logic/dph_fabric_ack.sv
// one fabric request channel: level request in, acknowledge out
`timescale 1ns/1ps
`default_nettype none
module dph_fabric_ack (
  input  wire logic CLK_I,
  input  wire logic NRST_I,
  input  wire logic enable_i,
  input  wire logic single_region_i,
  input  wire logic burst_req_i,
  input  wire logic single_req_i,
  input  wire logic xfer_done_i,
  output var  logic pending_o,
  output var  logic pending_burst_o,
  output var  logic ack_o
);
  typedef enum logic [1:0] {
    FA_IDLE = 2'b00,
    FA_BUSY = 2'b01,
    FA_ACK  = 2'b10,
    FA_DROP = 2'b11
  } dph_fa_e;
  dph_fa_e st_r, st_nxt;
  logic    burst_r, burst_nxt;
  logic    req_seen;
  logic    line_up;
  logic    ack_r, ack_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    burst_nxt = burst_r;
    // single line counts only inside the single region
    req_seen  = burst_req_i || (single_region_i && single_req_i);
    line_up   = burst_r ? burst_req_i : single_req_i;
    unique case (st_r)
      FA_IDLE:
      begin
        if (enable_i && req_seen)
        begin
          st_nxt    = FA_BUSY;
          burst_nxt = burst_req_i || !single_region_i;
        end
      end
      FA_BUSY:
      begin
        if (burst_req_i && !burst_r)
          burst_nxt = 1'b1; // late burst request turns a pending single block into a burst
        if (xfer_done_i)
          st_nxt = FA_ACK;
      end
      FA_ACK:
      begin
        if (!line_up)
          st_nxt = FA_DROP;
      end
      FA_DROP:
        st_nxt = FA_IDLE; // ack falls two cycles after the line
    endcase
    // decoded from the next state so the pin leaves a flop with no gate behind it
    ack_nxt = (st_nxt == FA_ACK) || (st_nxt == FA_DROP);
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      st_r    <= FA_IDLE;
      burst_r <= 1'b0;
      ack_r   <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      burst_r <= burst_nxt;
      ack_r   <= ack_nxt;
    end
  end

  assign pending_o       = (st_r == FA_BUSY);
  assign pending_burst_o = burst_r;
  assign ack_o           = ack_r;
endmodule : dph_fabric_ack
`default_nettype wire

// ### logic/dph_ctrl_end.sv
// controller end: 32 request interfaces, fabric handshake and valid/ready channel
`timescale 1ns/1ps
`default_nettype none
module dph_ctrl_end (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  dph_if.ctrl              fab [dph_pkg::NUM_FABRIC],
  input  wire logic [31:0] IF_ENABLE_I,
  input  wire logic [31:0] SINGLE_REGION_I,
  input  wire logic [31:0] XFER_DONE_I,
  input  wire logic        SHARED_TO_FABRIC_I,
  input  wire logic [31:0] PERIPH_BURST_I,
  input  wire logic [31:0] PERIPH_SINGLE_I,
  input  wire logic        THREAD_ACTIVE_I,
  input  wire logic        ACK_REQ_I,
  input  wire logic [1:0]  ACK_TYPE_I,
  input  wire logic [4:0]  CHAN_SEL_I,
  output logic      [31:0] PENDING_O,
  output logic      [31:0] PENDING_BURST_O,
  output logic      [31:0] PERIPH_ACK_O,
  output logic             REQ_TAKEN_O,
  output logic      [1:0]  REQ_TYPE_O,
  output logic             REQ_LAST_O,
  output logic             ACK_BUSY_O
);
  logic [31:0] en_eff;
  logic [31:0] burst_in;
  logic [31:0] single_in;
  logic [31:0] pend_w;
  logic [31:0] pburst_w;
  logic [31:0] ack_w;
  logic [31:0] pend_r, pburst_r, pack_r;

  function automatic logic id_usable(input logic [4:0] id, input logic shared_fab);
    logic ok;
    ok = !dph_pkg::RESERVED_IDS[id];
    if ((id == dph_pkg::ID_SHARED_LO) || (id == dph_pkg::ID_SHARED_HI))
      ok = shared_fab; // shared pair: serial controller owns it otherwise
    return ok;
  endfunction : id_usable

  function automatic logic type_ok(input logic [1:0] t);
    return t != dph_pkg::RQ_RSVD;
  endfunction : type_ok

  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_if
      if (g < 8)
      begin : g_fab
        assign burst_in[g]  = fab[g].fabric_burst_request;
        assign single_in[g] = fab[g].fabric_single_request;
        assign fab[g].fabric_transfer_acknowledge = pack_r[g];
      end
      else
      begin : g_int
        assign burst_in[g]  = PERIPH_BURST_I[g];
        assign single_in[g] = PERIPH_SINGLE_I[g];
      end
      assign en_eff[g] = IF_ENABLE_I[g] && id_usable(5'(g), SHARED_TO_FABRIC_I);
      dph_fabric_ack u_ack (
        .CLK_I           (CLK_I),
        .NRST_I          (NRST_I),
        .enable_i        (en_eff[g]),
        .single_region_i (SINGLE_REGION_I[g]),
        .burst_req_i     (burst_in[g]),
        .single_req_i    (single_in[g]),
        .xfer_done_i     (XFER_DONE_I[g]),
        .pending_o       (pend_w[g]),
        .pending_burst_o (pburst_w[g]),
        .ack_o           (ack_w[g])
      );
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pend_r   <= 32'h00000000;
      pburst_r <= 32'h00000000;
    end
    else
    begin
      pend_r   <= pend_w;
      pburst_r <= pburst_w;
    end
  end
  // ack already registered in the channel state machine
  assign pack_r          = ack_w;
  assign PENDING_O       = pend_r;
  assign PENDING_BURST_O = pburst_r;
  assign PERIPH_ACK_O    = ack_w;

  // valid/ready channel on the selected fabric slot (CHAN_SEL_I[2:0] picks one of 8)
  logic       rq_valid_sel;
  logic [1:0] rq_type_sel;
  logic       rq_last_sel;
  logic       ak_ready_sel;
  logic [7:0] rv, rl, ar;
  logic [15:0] rt;
  // channel handshake state
  logic       rdy_r, rdy_nxt;
  logic       akv_r, akv_nxt;
  logic [1:0] akt_r, akt_nxt;
  logic       tk_r, tk_nxt;
  logic [1:0] tt_r, tt_nxt;
  logic       tl_r, tl_nxt;
  generate
    for (g = 0; g < 8; g++)
    begin : g_sel
      assign rv[g] = fab[g].req_valid;
      assign rl[g] = fab[g].req_last;
      assign ar[g] = fab[g].ack_ready;
      assign rt[2*g +: 2] = fab[g].req_type;
      assign fab[g].req_ready = rdy_r && (CHAN_SEL_I[2:0] == 3'(g));
      assign fab[g].ack_valid = akv_r && (CHAN_SEL_I[2:0] == 3'(g));
      assign fab[g].ack_type  = akt_r;
    end
  endgenerate
  assign rq_valid_sel = rv[CHAN_SEL_I[2:0]];
  assign rq_last_sel  = rl[CHAN_SEL_I[2:0]];
  assign ak_ready_sel = ar[CHAN_SEL_I[2:0]];
  assign rq_type_sel  = rt[{CHAN_SEL_I[2:0], 1'b0} +: 2];

  always_comb
  begin
    rdy_nxt = 1'b0;
    akv_nxt = akv_r;
    akt_nxt = akt_r;
    tk_nxt  = 1'b0;
    tt_nxt  = tt_r;
    tl_nxt  = tl_r;
    if (THREAD_ACTIVE_I)
    begin
      // one-cycle ready pulse marks acceptance
      if (rq_valid_sel && !rdy_r)
        rdy_nxt = 1'b1;
      if (rq_valid_sel && rdy_r && type_ok(rq_type_sel))
      begin
        tk_nxt = 1'b1;
        tt_nxt = rq_type_sel;
        tl_nxt = (rq_type_sel != dph_pkg::RQ_FLUSH_ACK) && rq_last_sel;
      end
      if (akv_r)
      begin
        if (ak_ready_sel)
          akv_nxt = 1'b0; // only drop after the handshake
      end
      else if (ACK_REQ_I && type_ok(ACK_TYPE_I))
      begin
        akv_nxt = 1'b1;
        akt_nxt = ACK_TYPE_I; // type moves only while valid is low
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rdy_r <= 1'b0;
      akv_r <= 1'b0;
      akt_r <= dph_pkg::AK_SINGLE;
      tk_r  <= 1'b0;
      tt_r  <= dph_pkg::RQ_SINGLE;
      tl_r  <= 1'b0;
    end
    else
    begin
      rdy_r <= rdy_nxt;
      akv_r <= akv_nxt;
      akt_r <= akt_nxt;
      tk_r  <= tk_nxt;
      tt_r  <= tt_nxt;
      tl_r  <= tl_nxt;
    end
  end
  assign REQ_TAKEN_O = tk_r;
  assign REQ_TYPE_O  = tt_r;
  assign REQ_LAST_O  = tl_r;
  assign ACK_BUSY_O  = akv_r;
endmodule : dph_ctrl_end
`default_nettype wire

// ### logic/dph_periph_end.sv
// requester end: fabric level lines and valid/ready request side
`timescale 1ns/1ps
`default_nettype none
module dph_periph_end (
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  dph_if.periph           lnk,
  input  wire logic       BURST_WANT_I,
  input  wire logic       ITEM_AVAIL_I,
  input  wire logic       REQ_WANT_I,
  input  wire logic [1:0] REQ_TYPE_I,
  input  wire logic       REQ_LAST_I,
  input  wire logic       ACK_ACCEPT_I,
  output logic            ACK_SEEN_O,
  output logic [1:0]      ACK_TYPE_O,
  output logic            ACK_GOT_O
);
  logic       br_r, br_nxt;
  logic       sg_r, sg_nxt;
  logic       rv_r, rv_nxt;
  logic [1:0] rt_r, rt_nxt;
  logic       rl_r, rl_nxt;
  logic       ar_r, ar_nxt;
  logic       as_r, as_nxt;
  logic [1:0] at_r, at_nxt;
  logic       ag_r, ag_nxt;

  always_comb
  begin
    br_nxt = br_r;
    sg_nxt = sg_r;
    rv_nxt = rv_r;
    rt_nxt = rt_r;
    rl_nxt = rl_r;
    ar_nxt = 1'b0;
    as_nxt = 1'b0;
    at_nxt = at_r;
    ag_nxt = lnk.fabric_transfer_acknowledge;
    // hold burst until acknowledge, then drop
    if (lnk.fabric_transfer_acknowledge)
      br_nxt = 1'b0;
    else if (BURST_WANT_I)
      br_nxt = 1'b1;
    // single reflects availability, held until acknowledge
    if (lnk.fabric_transfer_acknowledge)
      sg_nxt = 1'b0;
    else if (!sg_r)
      sg_nxt = ITEM_AVAIL_I;
    // new request only when no request is pending
    if (rv_r && lnk.req_ready)
      rv_nxt = 1'b0;
    else if (!rv_r && REQ_WANT_I && (REQ_TYPE_I != dph_pkg::RQ_RSVD))
    begin
      rv_nxt = 1'b1;
      rt_nxt = REQ_TYPE_I;
      rl_nxt = REQ_LAST_I;
    end
    if (lnk.ack_valid && ACK_ACCEPT_I && !ar_r)
      ar_nxt = 1'b1;
    if (lnk.ack_valid && ar_r && (lnk.ack_type != dph_pkg::AK_RSVD))
    begin
      as_nxt = 1'b1;
      at_nxt = lnk.ack_type;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      br_r <= 1'b0;
      sg_r <= 1'b0;
      rv_r <= 1'b0;
      rt_r <= dph_pkg::RQ_SINGLE;
      rl_r <= 1'b0;
      ar_r <= 1'b0;
      as_r <= 1'b0;
      at_r <= dph_pkg::AK_SINGLE;
      ag_r <= 1'b0;
    end
    else
    begin
      br_r <= br_nxt;
      sg_r <= sg_nxt;
      rv_r <= rv_nxt;
      rt_r <= rt_nxt;
      rl_r <= rl_nxt;
      ar_r <= ar_nxt;
      as_r <= as_nxt;
      at_r <= at_nxt;
      ag_r <= ag_nxt;
    end
  end
  assign lnk.fabric_burst_request  = br_r;
  assign lnk.fabric_single_request = sg_r;
  assign lnk.req_valid = rv_r;
  assign lnk.req_type  = rt_r;
  assign lnk.req_last  = rl_r;
  assign lnk.ack_ready = ar_r;
  assign ACK_SEEN_O = as_r;
  assign ACK_TYPE_O = at_r;
  assign ACK_GOT_O  = ag_r;
endmodule : dph_periph_end
`default_nettype wire

// ### sim/dph_link_monitor.sv
// checker: handshake relations on one controller/requester link
`timescale 1ns/1ps
`default_nettype none
module dph_link_monitor (
  input wire logic       CLK_I,
  input wire logic       NRST_I,
  input wire logic       fabric_burst_request,
  input wire logic       fabric_single_request,
  input wire logic       fabric_transfer_acknowledge,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [1:0] req_type,
  input wire logic       req_last,
  input wire logic       ack_valid,
  input wire logic       ack_ready,
  input wire logic [1:0] ack_type
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  ack_cause_a: assert property ($rose(fabric_transfer_acknowledge) |->
    $past(fabric_burst_request) || $past(fabric_single_request)) else $error("ack without request");
  ack_release_a: assert property ($fell(fabric_transfer_acknowledge) |-> !$past(fabric_burst_request))
    else $error("ack dropped while burst high");
  ack_drop_a: assert property (fabric_transfer_acknowledge && !fabric_burst_request && !fabric_single_request
    |-> ##[1:2] !fabric_transfer_acknowledge) else $error("ack not dropped");
  burst_hold_a: assert property (fabric_burst_request && !fabric_transfer_acknowledge |=> fabric_burst_request)
    else $error("burst dropped early");
  ready_pulse_a: assert property (req_ready |=> !req_ready) else $error("ready longer than one cycle");
  ready_valid_a: assert property (req_ready |-> req_valid) else $error("ready without valid");
  req_hold_a: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_type) && $stable(req_last)) else $error("request changed before ready");
  ackv_hold_a: assert property (ack_valid && !ack_ready |=> ack_valid && $stable(ack_type))
    else $error("ack channel changed before ready");
  ackv_drop_a: assert property (ack_valid && ack_ready |=> !ack_valid) else $error("ack valid not dropped");
  ack_code_a: assert property (ack_valid |-> ack_type != dph_pkg::AK_RSVD) else $error("reserved ack type");
  single_hold_a: assert property (fabric_single_request && !fabric_transfer_acknowledge |=>
    fabric_single_request) else $error("single dropped early");
  ackr_valid_a: assert property (ack_ready |-> ack_valid) else $error("ack ready without valid");
  cover property ($rose(fabric_transfer_acknowledge));
  cover property (req_valid && req_ready);
  cover property (ack_valid && ack_ready);
endmodule : dph_link_monitor
`default_nettype wire

// ### sim/dma_peripheral_request_handshake_tb.sv
// testbench: both ends joined, fabric level and valid/ready scenarios
`timescale 1ns/1ps
`default_nettype none
module dma_peripheral_request_handshake_tb;
  logic        clk = 1'b0, nrst = 1'b0, shared = 1'b0, thr = 1'b0, ackreq = 1'b0;
  logic [31:0] en = '0, region = '0, done = '0, pb = '0, ps = '0;
  logic [7:0]  bw = '0, ia = '0, rw = '0, rl = '0, aa = '0, seen, got;
  logic [1:0]  rt [8], at [8], acktype = 2'h0, rtype;
  logic [4:0]  chsel = 5'h00;
  logic [31:0] pend, pendb, pack;
  logic        taken, rlast, busy;
  int          err_total = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  dph_if lnk_if [8] ();
  dph_ctrl_end i_dph_ctrl_end (.CLK_I(clk), .NRST_I(nrst), .fab(lnk_if), .IF_ENABLE_I(en), .SINGLE_REGION_I(region),
    .XFER_DONE_I(done), .SHARED_TO_FABRIC_I(shared), .PERIPH_BURST_I(pb), .PERIPH_SINGLE_I(ps),
    .THREAD_ACTIVE_I(thr), .ACK_REQ_I(ackreq), .ACK_TYPE_I(acktype), .CHAN_SEL_I(chsel), .PENDING_O(pend),
    .PENDING_BURST_O(pendb), .PERIPH_ACK_O(pack), .REQ_TAKEN_O(taken), .REQ_TYPE_O(rtype), .REQ_LAST_O(rlast),
    .ACK_BUSY_O(busy));
  for (genvar g = 0; g < 8; g++)
  begin : g_req
    dph_periph_end i_dph_periph_end (.CLK_I(clk), .NRST_I(nrst), .lnk(lnk_if[g]), .BURST_WANT_I(bw[g]),
      .ITEM_AVAIL_I(ia[g]), .REQ_WANT_I(rw[g]), .REQ_TYPE_I(rt[g]), .REQ_LAST_I(rl[g]), .ACK_ACCEPT_I(aa[g]),
      .ACK_SEEN_O(seen[g]), .ACK_TYPE_O(at[g]), .ACK_GOT_O(got[g]));
  end
  dph_link_monitor i_dph_link_monitor (.CLK_I(clk), .NRST_I(nrst),
    .fabric_burst_request(lnk_if[0].fabric_burst_request), .fabric_single_request(lnk_if[0].fabric_single_request),
    .fabric_transfer_acknowledge(lnk_if[0].fabric_transfer_acknowledge), .req_valid(lnk_if[0].req_valid),
    .req_ready(lnk_if[0].req_ready), .req_type(lnk_if[0].req_type), .req_last(lnk_if[0].req_last),
    .ack_valid(lnk_if[0].ack_valid), .ack_ready(lnk_if[0].ack_ready), .ack_type(lnk_if[0].ack_type));
  task chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("wrong value at %0t: port mismatch", $time);
    end
  endtask : chk
  task print_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_total++;
      print_verdict();
    end
  end
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task fab_xfer(input int i, input logic b, input logic s, input logic eb, input logic late);
    int k;
    @(posedge clk);
    en[i] <= 1'b1;
    region[i] <= s;
    if (i < 8)
    begin
      bw[i[2:0]] <= b && !late;
      ia[i[2:0]] <= s;
    end
    else
      pb[i] <= b;
    for (k = 0; k < 9 && pend[i] !== 1'b1; k++)
      @(negedge clk);
    chk(pend[i] === 1'b1);
    chk(pendb[i] === eb);
    // burst arrives after a single was taken: block must end as a burst
    if (late)
    begin
      @(posedge clk);
      bw[i[2:0]] <= 1'b1;
      tick(4);
      chk(pendb[i] === 1'b1);
    end
    tick(2);
    chk(pack[i] === 1'b0);
    @(posedge clk);
    done[i] <= 1'b1;
    @(posedge clk);
    done[i] <= 1'b0;
    for (k = 0; k < 5 && pack[i] !== 1'b1; k++)
      @(negedge clk);
    chk(pack[i] === 1'b1);
    @(posedge clk);
    bw <= '0;
    ia <= '0;
    pb <= '0;
    for (k = 0; k < 9 && pack[i] !== 1'b0; k++)
      @(negedge clk);
    chk(pack[i] === 1'b0 && pend[i] === 1'b0);
    if (i < 8)
      chk(got[i[2:0]] === 1'b1);
    @(posedge clk);
    en[i] <= 1'b0;
    region[i] <= 1'b0;
  endtask : fab_xfer
  // wanted lines stay up inside the requester; later scenarios reuse them
  task refuse(input int i, input logic e, input logic b);
    @(posedge clk);
    en[i] <= e;
    if (i < 8)
      {bw[i[2:0]], ia[i[2:0]]} <= {b, !b};
    else
      pb[i] <= b;
    tick(6);
    chk(pend[i] === 1'b0);
    @(posedge clk);
    en[i] <= 1'b0;
  endtask : refuse
  task req_one(input logic [1:0] t, input logic l, input logic tk);
    int k;
    @(posedge clk);
    {rt[0], rl[0], rw[0]} <= {t, l, 1'b1};
    // one-cycle want: a held want would launch a second request
    @(posedge clk);
    rw[0] <= 1'b0;
    for (k = 0; k < 9 && taken !== 1'b1; k++)
      @(negedge clk);
    chk(taken === tk);
    if (tk)
      chk(rtype === t && rlast === (l && t != 2'h2));
    tick(3);
  endtask : req_one
  task ack_one(input logic [1:0] t);
    int k;
    @(posedge clk);
    {acktype, ackreq} <= {t, 1'b1};
    @(posedge clk);
    ackreq <= 1'b0;
    tick(3);
    if (t == 2'h3)
    begin
      chk(busy === 1'b0 && lnk_if[0].ack_valid === 1'b0);
      return;
    end
    chk(busy === 1'b1 && lnk_if[0].ack_valid === 1'b1);
    @(posedge clk);
    aa[0] <= 1'b1;
    for (k = 0; k < 6 && seen[0] !== 1'b1; k++)
      @(negedge clk);
    chk(seen[0] === 1'b1 && at[0] === t);
    @(posedge clk);
    aa[0] <= 1'b0;
    tick(2);
    chk(busy === 1'b0);
  endtask : ack_one
  initial
  begin
    foreach (rt[j])
      rt[j] = 2'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    thr <= 1'b1;
    fab_xfer(0, 1'b1, 1'b0, 1'b1, 1'b0);
    refuse(1, 1'b1, 1'b0);
    fab_xfer(1, 1'b0, 1'b1, 1'b0, 1'b0);
    fab_xfer(3, 1'b1, 1'b1, 1'b1, 1'b0);
    fab_xfer(0, 1'b1, 1'b1, 1'b0, 1'b1);
    refuse(2, 1'b0, 1'b1);
    refuse(6, 1'b1, 1'b1);
    refuse(24, 1'b1, 1'b1);
    refuse(25, 1'b1, 1'b1);
    refuse(27, 1'b1, 1'b1);
    shared <= 1'b1;
    fab_xfer(6, 1'b1, 1'b0, 1'b1, 1'b0);
    fab_xfer(26, 1'b1, 1'b0, 1'b1, 1'b0);
    for (int t = 0; t < 4; t++)
      req_one(t[1:0], 1'b1, t != 3);
    req_one(2'h1, 1'b0, 1'b1);
    for (int t = 0; t < 4; t++)
      ack_one(t[1:0]);
    @(posedge clk);
    thr <= 1'b0;
    req_one(2'h0, 1'b0, 1'b0);
    print_verdict();
  end
endmodule : dma_peripheral_request_handshake_tb
`default_nettype wire
